/* adc_bias_channel_config_regs.sv */
// register slice: pll lock irq latch, bias/full-scale and channel 1 setup
// Overview of operation
// - pll lock sets status bit 6, read clears
// - mic bias level field, bits 6-4
// - full-scale select field, bits 1-0
// - bit 7 selects microphone or line input
// - input source field bits 6-5
// - bit 4 selects ac or dc coupling
// - impedance field bits 3-2, analog only
// - bias register at 0x3B, reset zero
// - channel register at 0x3C, reset zero
// - bit 0 enables automatic gain control
// - mask bit 6 suppresses pll irq, resets set
// - readback select shows only unmasked latches
//
// Design decision made here: the address-and-strobe port.
module adc_bias_channel_config_regs
(
    input  wire logic       core_clk_in,         // core clock, 20 MHz
    input  wire logic       rst_n_in,            // async reset, active low
    input  wire logic       clk_en_in,           // clock enable, freezes all
    input  wire logic [7:0] addr_in,             // register address
    input  wire logic [7:0] wdata_in,            // write data
    input  wire logic       wr_in,               // write strobe
    input  wire logic       rd_in,               // read strobe
    output logic      [7:0] rdata_out,           // read data, next cycle
    input  wire logic       pll_lock_evt_in,     // pll lock event pulse
    output logic      [2:0] mic_bias_level_out,  // mic bias level code
    output logic      [1:0] adc_full_scale_sel_out, // full-scale code
    output logic            ch1_input_kind_out,  // 0 mic, 1 line
    output logic      [1:0] ch1_input_source_out, // input source code
    output logic            ch1_coupling_out,    // 0 ac, 1 dc (analog)
    output logic      [1:0] ch1_input_impedance_out, // impedance (analog)
    output logic            ch1_auto_gain_en_out, // agc enable
    output logic            irq_out              // interrupt, active high
);
    logic [7:0] bias_adc_setup_r;
    logic [7:0] channel1_setup0_r;
    logic       irq_mask6_r;
    logic       latch_readback_sel_r;
    logic       pll_lock_flag;
    logic [7:0] rdata_nxt;
    logic       pll_lock_visible;

    // address decode
    wire hit_bias = addr_in == adc_cfg_pkg::BIAS_ADC_SETUP_OFF;
    wire hit_ch1  = addr_in == adc_cfg_pkg::CHANNEL1_SETUP0_OFF;
    wire hit_cfg  = addr_in == adc_cfg_pkg::IRQ_CFG_OFF;
    wire hit_mask = addr_in == adc_cfg_pkg::IRQ_MASK0_OFF;
    wire hit_stat = addr_in == adc_cfg_pkg::LATCHED_IRQ_STATUS0_OFF;
    wire wr_bias  = wr_in & hit_bias;
    wire wr_ch1   = wr_in & hit_ch1;
    wire wr_cfg   = wr_in & hit_cfg;
    wire wr_mask  = wr_in & hit_mask;
    wire stat_rd  = rd_in & hit_stat & clk_en_in;

    // latched pll lock status, cleared by a status read
    sticky_irq_bit u_pll_lock
    (
        .core_clk_in (core_clk_in),
        .rst_n_in    (rst_n_in),
        .clk_en_in   (clk_en_in),
        .event_in    (pll_lock_evt_in),
        .clear_in    (stat_rd),
        .flag_out    (pll_lock_flag)
    );

    // readback view honours the latch readback select
    assign pll_lock_visible = pll_lock_flag &
                              ~(latch_readback_sel_r & irq_mask6_r);

    // read mux, unmapped addresses read zero
    always_comb
    begin
        rdata_nxt = 8'h00;
        if (hit_bias)
            rdata_nxt = bias_adc_setup_r;
        else if (hit_ch1)
            rdata_nxt = channel1_setup0_r;
        else if (hit_cfg)
            rdata_nxt[adc_cfg_pkg::LATCH_READBACK_BIT] = latch_readback_sel_r;
        else if (hit_mask)
            rdata_nxt[adc_cfg_pkg::PLL_LOCK_BIT] = irq_mask6_r;
        else if (hit_stat)
            rdata_nxt[adc_cfg_pkg::PLL_LOCK_BIT] = pll_lock_visible;
    end

    // read data register
    always_ff @(posedge core_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            rdata_out <= 8'h00;
        else if (clk_en_in)
            rdata_out <= rd_in ? rdata_nxt : 8'h00;
    end

    // configuration registers, reserved bits masked off
    always_ff @(posedge core_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            bias_adc_setup_r  <= adc_cfg_pkg::BIAS_ADC_SETUP_RST;
            channel1_setup0_r <= adc_cfg_pkg::CHANNEL1_SETUP0_RST;
        end
        else if (clk_en_in)
        begin
            if (wr_bias)
                bias_adc_setup_r <= wdata_in &
                                    adc_cfg_pkg::BIAS_ADC_SETUP_WMASK;
            if (wr_ch1)
                channel1_setup0_r <= wdata_in &
                                     adc_cfg_pkg::CHANNEL1_SETUP0_WMASK;
        end
    end

    // interrupt mask and readback select
    always_ff @(posedge core_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            irq_mask6_r          <= adc_cfg_pkg::IRQ_MASK_RST;
            latch_readback_sel_r <= adc_cfg_pkg::IRQ_CFG_RST[2];
        end
        else if (clk_en_in)
        begin
            if (wr_mask)
                irq_mask6_r <= wdata_in[adc_cfg_pkg::PLL_LOCK_BIT];
            if (wr_cfg)
                latch_readback_sel_r <=
                    wdata_in[adc_cfg_pkg::LATCH_READBACK_BIT];
        end
    end

    // interrupt output, level while an unmasked latch is set
    assign irq_out = pll_lock_flag & ~irq_mask6_r;

    // field outputs
    assign mic_bias_level_out = bias_adc_setup_r[adc_cfg_pkg::MIC_BIAS_LSB +: 3];
    assign adc_full_scale_sel_out =
        bias_adc_setup_r[adc_cfg_pkg::FULL_SCALE_LSB +: 2];
    // channel 1 fields
    assign ch1_input_kind_out =
        channel1_setup0_r[adc_cfg_pkg::INPUT_KIND_BIT];
    assign ch1_input_source_out =
        channel1_setup0_r[adc_cfg_pkg::INPUT_SOURCE_LSB +: 2];
    assign ch1_auto_gain_en_out =
        channel1_setup0_r[adc_cfg_pkg::AUTO_GAIN_BIT];
    // analog-only settings, forced to default for pdm
    wire src_analog = channel1_setup0_r[adc_cfg_pkg::INPUT_SOURCE_LSB + 1]
                      == 1'b0;
    assign ch1_coupling_out = src_analog &
        channel1_setup0_r[adc_cfg_pkg::COUPLING_BIT];
    assign ch1_input_impedance_out = src_analog ?
        channel1_setup0_r[adc_cfg_pkg::IMPEDANCE_LSB +: 2] : 2'h0;

    // a pll lock event is visible in the latch one cycle later
    property p_lock_sets;
        @(posedge core_clk_in) disable iff (!rst_n_in)
        (clk_en_in && pll_lock_evt_in) |=> pll_lock_flag;
    endproperty
    a_lock_sets: assert property (p_lock_sets)
        else $error("pll lock event not latched");

    // a status read without a new event clears the latch
    property p_read_clears;
        @(posedge core_clk_in) disable iff (!rst_n_in)
        (stat_rd && !pll_lock_evt_in) |=> !pll_lock_flag;
    endproperty
    a_read_clears: assert property (p_read_clears)
        else $error("status read did not clear latch");

    // bias register write shows in readback with reserved bits zero
    property p_bias_wr;
        @(posedge core_clk_in) disable iff (!rst_n_in)
        (clk_en_in && wr_bias) ##1 (clk_en_in && rd_in && hit_bias) |=>
        (rdata_out[7] == 1'b0 && rdata_out[3:2] == 2'h0 &&
         rdata_out[6:4] == mic_bias_level_out);
    endproperty
    a_bias_wr: assert property (p_bias_wr)
        else $error("bias register readback wrong");

    // full scale output follows write data
    property p_fscale;
        @(posedge core_clk_in) disable iff (!rst_n_in)
        (clk_en_in && wr_bias) |=>
        adc_full_scale_sel_out == $past(wdata_in[1:0]);
    endproperty
    a_fscale: assert property (p_fscale)
        else $error("full scale select not updated");

    // channel register bit 1 always reads zero
    property p_ch1_res;
        @(posedge core_clk_in) disable iff (!rst_n_in)
        (clk_en_in && rd_in && hit_ch1) |=> rdata_out[1] == 1'b0;
    endproperty
    a_ch1_res: assert property (p_ch1_res)
        else $error("channel reserved bit not zero");

    // channel kind, source and auto gain fields follow write data
    property p_ch1_fields;
        @(posedge core_clk_in) disable iff (!rst_n_in)
        (clk_en_in && wr_ch1) |=>
        (ch1_input_kind_out == $past(wdata_in[7]) &&
         ch1_input_source_out == $past(wdata_in[6:5]) &&
         ch1_auto_gain_en_out == $past(wdata_in[0]));
    endproperty
    a_ch1_fields: assert property (p_ch1_fields)
        else $error("channel fields not updated");

    // interrupt only while latch set and unmasked
    property p_irq;
        @(posedge core_clk_in) disable iff (!rst_n_in)
        irq_out |-> (pll_lock_flag && !irq_mask6_r);
    endproperty
    a_irq: assert property (p_irq)
        else $error("interrupt with masked or clear latch");

    // with select set, a masked latch reads as zero
    property p_readback;
        @(posedge core_clk_in) disable iff (!rst_n_in)
        (clk_en_in && rd_in && hit_stat && latch_readback_sel_r &&
         irq_mask6_r) |=> rdata_out[6] == 1'b0;
    endproperty
    a_readback: assert property (p_readback)
        else $error("masked latch visible in readback");

    // pdm source forces analog-only settings off
    property p_pdm;
        @(posedge core_clk_in) disable iff (!rst_n_in)
        (ch1_input_source_out == 2'h2) |->
        (!ch1_coupling_out && ch1_input_impedance_out == 2'h0);
    endproperty
    a_pdm: assert property (p_pdm)
        else $error("analog settings active for pdm");

    // an unmasked lock event raises the interrupt one cycle later
    property p_irq_rise;
        @(posedge core_clk_in) disable iff (!rst_n_in)
        (clk_en_in && pll_lock_evt_in && !irq_mask6_r && !wr_mask) |=>
        irq_out;
    endproperty
    a_irq_rise: assert property (p_irq_rise)
        else $error("unmasked lock event did not raise irq");

    // a low clock enable freezes the latched status
    property p_flag_frozen;
        @(posedge core_clk_in) disable iff (!rst_n_in)
        !clk_en_in |=> $stable(pll_lock_flag);
    endproperty
    a_flag_frozen: assert property (p_flag_frozen)
        else $error("latch changed while clock enable low");

    // a low clock enable freezes the configuration registers
    property p_cfg_frozen;
        @(posedge core_clk_in) disable iff (!rst_n_in)
        !clk_en_in |=>
        ($stable(bias_adc_setup_r) && $stable(channel1_setup0_r));
    endproperty
    a_cfg_frozen: assert property (p_cfg_frozen)
        else $error("configuration changed while clock enable low");

    // reserved bits of the bias register never hold a one
    property p_bias_res;
        @(posedge core_clk_in) disable iff (!rst_n_in)
        (bias_adc_setup_r[7] == 1'b0 && bias_adc_setup_r[3:2] == 2'h0);
    endproperty
    a_bias_res: assert property (p_bias_res)
        else $error("bias reserved bit stored");

    // reserved bit of the channel register never holds a one
    property p_ch1_res_r;
        @(posedge core_clk_in) disable iff (!rst_n_in)
        channel1_setup0_r[1] == 1'b0;
    endproperty
    a_ch1_res_r: assert property (p_ch1_res_r)
        else $error("channel reserved bit stored");

    // mic bias level follows write data
    property p_mic_bias;
        @(posedge core_clk_in) disable iff (!rst_n_in)
        (clk_en_in && wr_bias) |=>
        mic_bias_level_out == $past(wdata_in[6:4]);
    endproperty
    a_mic_bias: assert property (p_mic_bias)
        else $error("mic bias level not updated");

    // analog source passes coupling and impedance through
    property p_analog_fields;
        @(posedge core_clk_in) disable iff (!rst_n_in)
        (clk_en_in && wr_ch1 && !wdata_in[6]) |=>
        (ch1_coupling_out == $past(wdata_in[4]) &&
         ch1_input_impedance_out == $past(wdata_in[3:2]));
    endproperty
    a_analog_fields: assert property (p_analog_fields)
        else $error("analog coupling or impedance not updated");

    // auto gain enable follows write data
    property p_agc;
        @(posedge core_clk_in) disable iff (!rst_n_in)
        (clk_en_in && wr_ch1) |=>
        ch1_auto_gain_en_out == $past(wdata_in[0]);
    endproperty
    a_agc: assert property (p_agc)
        else $error("auto gain enable not updated");

    // reads of unmapped addresses return zero
    property p_unmapped;
        @(posedge core_clk_in) disable iff (!rst_n_in)
        (clk_en_in && rd_in && !hit_bias && !hit_ch1 && !hit_cfg &&
         !hit_mask && !hit_stat) |=> rdata_out == 8'h00;
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped address read not zero");
endmodule

/* adc_cfg_pkg.sv */
// package: register offsets, field layouts, reset values and encodings
package adc_cfg_pkg;
    // register offsets (byte addresses on the plain control port)
    localparam logic [7:0] BIAS_ADC_SETUP_OFF      = 8'h3B;
    localparam logic [7:0] CHANNEL1_SETUP0_OFF     = 8'h3C;
    localparam logic [7:0] IRQ_CFG_OFF             = 8'h32;
    localparam logic [7:0] IRQ_MASK0_OFF           = 8'h33;
    localparam logic [7:0] LATCHED_IRQ_STATUS0_OFF = 8'h36;
    // reset values
    localparam logic [7:0] BIAS_ADC_SETUP_RST  = 8'h00;
    localparam logic [7:0] CHANNEL1_SETUP0_RST = 8'h00;
    localparam logic [7:0] IRQ_CFG_RST         = 8'h00;
    localparam logic       IRQ_MASK_RST        = 1'h1;
    // writable bit masks, reserved bits hold zero
    localparam logic [7:0] BIAS_ADC_SETUP_WMASK  = 8'h73;
    localparam logic [7:0] CHANNEL1_SETUP0_WMASK = 8'hFD;
    // field positions
    localparam int PLL_LOCK_BIT       = 6;
    localparam int LATCH_READBACK_BIT = 2;
    localparam int MIC_BIAS_LSB       = 4;
    localparam int FULL_SCALE_LSB     = 0;
    localparam int INPUT_KIND_BIT     = 7;
    localparam int INPUT_SOURCE_LSB   = 5;
    localparam int COUPLING_BIT       = 4;
    localparam int IMPEDANCE_LSB      = 2;
    localparam int AUTO_GAIN_BIT      = 0;
    // field encodings
    typedef enum logic [2:0]
    {
        MIC_BIAS_VREF       = 3'h0,
        MIC_BIAS_VREF_X1096 = 3'h1,
        MIC_BIAS_SUPPLY     = 3'h6
    } mic_bias_type;
    typedef enum logic [1:0]
    {
        FULL_SCALE_2V75  = 2'h0,
        FULL_SCALE_2V50  = 2'h1,
        FULL_SCALE_1V375 = 2'h2
    } full_scale_type;
    typedef enum logic [1:0]
    {
        SRC_ANALOG_DIFF = 2'h0,
        SRC_ANALOG_SE   = 2'h1,
        SRC_PDM         = 2'h2
    } input_source_type;
    typedef enum logic [1:0]
    {
        IMP_2K5 = 2'h0,
        IMP_10K = 2'h1,
        IMP_20K = 2'h2
    } impedance_type;
endpackage

/* sticky_irq_bit.sv */
// one sticky interrupt bit: set by an event, cleared when read
module sticky_irq_bit
(
    input  wire logic core_clk_in,  // core clock
    input  wire logic rst_n_in,     // async reset, active low
    input  wire logic clk_en_in,    // clock enable
    input  wire logic event_in,     // event pulse
    input  wire logic clear_in,     // clear request (read of status)
    output logic      flag_out      // sticky flag
);
    logic flag_nxt;

    // set wins over a clear in the same cycle
    assign flag_nxt = event_in | (flag_out & ~clear_in);

    // flag register
    always_ff @(posedge core_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            flag_out <= 1'b0;
        else if (clk_en_in)
            flag_out <= flag_nxt;
    end
endmodule

/* tb_adc_bias_channel_config_regs.sv */
// testbench for the bias, full-scale, channel 1 setup and pll irq registers
module tb_adc_bias_channel_config_regs;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct packed {logic [7:0] addr; logic [7:0] wd; logic [7:0] rexp;}
        row_type;
    logic       core_clk_in, rst_n_in, clk_en_in, wr_in, rd_in;
    logic       pll_lock_evt_in, irq_out, ch1_input_kind_out;
    logic       ch1_coupling_out, ch1_auto_gain_en_out;
    logic [7:0] addr_in, wdata_in, rdata_out, rd_val, bias_m, chan_m;
    logic [2:0] mic_bias_level_out;
    logic [1:0] adc_full_scale_sel_out, ch1_input_source_out;
    logic [1:0] ch1_input_impedance_out;
    int         fails, tests_run, cycles;
    row_type    rows [12];

    adc_bias_channel_config_regs dut (.core_clk_in(core_clk_in),
        .rst_n_in(rst_n_in), .clk_en_in(clk_en_in), .addr_in(addr_in),
        .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
        .rdata_out(rdata_out), .pll_lock_evt_in(pll_lock_evt_in),
        .mic_bias_level_out(mic_bias_level_out),
        .adc_full_scale_sel_out(adc_full_scale_sel_out),
        .ch1_input_kind_out(ch1_input_kind_out),
        .ch1_input_source_out(ch1_input_source_out),
        .ch1_coupling_out(ch1_coupling_out),
        .ch1_input_impedance_out(ch1_input_impedance_out),
        .ch1_auto_gain_en_out(ch1_auto_gain_en_out), .irq_out(irq_out));

    // 20 MHz core clock
    initial
    begin
        core_clk_in = 1'b0;
        forever #25 core_clk_in = ~core_clk_in;
    end

    // cut a hang short
    always @(posedge core_clk_in)
    begin
        cycles++;
        if (cycles == 1000)
        begin
            fails++;
            give_verdict();
        end
    end

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic check(input string what, input logic [11:0] exp,
                         input logic [11:0] got);
        tests_run++;
        if (got !== exp)
        begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    // one-cycle write strobe
    task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk_in);
        addr_in  <= a;
        wdata_in <= d;
        wr_in    <= 1'b1;
        @(posedge core_clk_in);
        wr_in    <= 1'b0;
    endtask

    // one-cycle read strobe, data taken in the following cycle
    task automatic reg_read(input logic [7:0] a, input logic evt,
                            output logic [7:0] d);
        @(posedge core_clk_in);
        addr_in         <= a;
        rd_in           <= 1'b1;
        pll_lock_evt_in <= evt;
        @(posedge core_clk_in);
        rd_in           <= 1'b0;
        pll_lock_evt_in <= 1'b0;
        #1 d = rdata_out;
    endtask

    task automatic pulse_event();
        @(posedge core_clk_in);
        pll_lock_evt_in <= 1'b1;
        @(posedge core_clk_in);
        pll_lock_evt_in <= 1'b0;
        #1;
    endtask

    // field outputs expected from the model copies; pdm/reserved gate analog
    task automatic check_fields();
        logic [1:0] src;
        src = chan_m[6:5];
        check("fields", {bias_m[6:4], bias_m[1:0], chan_m[7], src,
            (src[1] ? 1'b0 : chan_m[4]), (src[1] ? 2'b00 : chan_m[3:2]),
            chan_m[0]}, {mic_bias_level_out, adc_full_scale_sel_out,
            ch1_input_kind_out, ch1_input_source_out, ch1_coupling_out,
            ch1_input_impedance_out, ch1_auto_gain_en_out});
    endtask

    initial
    begin
        {rst_n_in, wr_in, rd_in, pll_lock_evt_in} = 4'h0;
        clk_en_in = 1'b1;
        addr_in   = 8'h00;
        wdata_in  = 8'h00;
        bias_m    = 8'h00;
        chan_m    = 8'h00;
        rows = '{'{8'h3B, 8'h00, 8'h00}, '{8'h3B, 8'h11, 8'h11},
                 '{8'h3B, 8'h62, 8'h62}, '{8'h3B, 8'hFF, 8'h73},
                 '{8'h3C, 8'h80, 8'h80}, '{8'h3C, 8'h34, 8'h34},
                 '{8'h3C, 8'h58, 8'h58}, '{8'h3C, 8'h28, 8'h28},
                 '{8'h3C, 8'h9D, 8'h9D}, '{8'h3C, 8'hFF, 8'hFD},
                 '{8'h3C, 8'h01, 8'h01}, '{8'h50, 8'hFF, 8'h00}};
        repeat (5) @(posedge core_clk_in);
        rst_n_in <= 1'b1;
        // reset values
        reg_read(8'h3B, 1'b0, rd_val);
        check("bias reset", 12'(8'h00), 12'(rd_val));
        reg_read(8'h3C, 1'b0, rd_val);
        check("chan reset", 12'(8'h00), 12'(rd_val));
        reg_read(8'h33, 1'b0, rd_val);
        check("mask reset", 12'(8'h40), 12'(rd_val));
        check_fields();
        $display("test reset values done");
        // table of writes, readbacks and field outputs
        foreach (rows[i])
        begin
            reg_write(rows[i].addr, rows[i].wd);
            reg_read(rows[i].addr, 1'b0, rd_val);
            check("readback", 12'(rows[i].rexp), 12'(rd_val));
            if (rows[i].addr == 8'h3B)
                bias_m = rows[i].rexp;
            if (rows[i].addr == 8'h3C)
                chan_m = rows[i].rexp;
            check_fields();
        end
        $display("test register table done");
        // masked event latches but keeps irq low, read clears it
        pulse_event();
        check("irq masked", 12'(1'b0), 12'(irq_out));
        reg_read(8'h36, 1'b0, rd_val);
        check("latch set", 12'(8'h40), 12'(rd_val));
        reg_read(8'h36, 1'b0, rd_val);
        check("latch cleared", 12'(8'h00), 12'(rd_val));
        // unmasked event raises irq until read
        reg_write(8'h33, 8'h00);
        pulse_event();
        check("irq raised", 12'(1'b1), 12'(irq_out));
        reg_read(8'h36, 1'b1, rd_val);
        check("latch seen", 12'(8'h40), 12'(rd_val));
        reg_read(8'h36, 1'b0, rd_val);
        check("set wins", 12'(8'h40), 12'(rd_val));
        check("irq after read", 12'(1'b0), 12'(irq_out));
        $display("test pll lock latch done");
        // readback select hides a masked latch
        reg_write(8'h33, 8'h40);
        reg_write(8'h32, 8'h04);
        pulse_event();
        reg_read(8'h36, 1'b0, rd_val);
        check("masked readback", 12'(8'h00), 12'(rd_val));
        check("irq masked", 12'(1'b0), 12'(irq_out));
        $display("test readback select done");
        // write followed at once by a read of the same register
        @(posedge core_clk_in);
        addr_in  <= 8'h3B;
        wdata_in <= 8'h21;
        wr_in    <= 1'b1;
        @(posedge core_clk_in);
        wr_in    <= 1'b0;
        rd_in    <= 1'b1;
        @(posedge core_clk_in);
        rd_in    <= 1'b0;
        #1 check("back to back", 12'(8'h21), 12'(rdata_out));
        bias_m = 8'h21;
        check_fields();
        $display("test back to back done");
        // writes are ignored while the clock enable is low
        @(posedge core_clk_in);
        clk_en_in <= 1'b0;
        reg_write(8'h3B, 8'h00);
        clk_en_in <= 1'b1;
        reg_read(8'h3B, 1'b0, rd_val);
        check("frozen write", 12'(bias_m), 12'(rd_val));
        $display("test clock enable done");
        // reset in mid-run
        @(posedge core_clk_in);
        rst_n_in <= 1'b0;
        @(posedge core_clk_in);
        rst_n_in <= 1'b1;
        bias_m = 8'h00;
        chan_m = 8'h00;
        #1 check_fields();
        check("irq after reset", 12'(1'b0), 12'(irq_out));
        reg_read(8'h33, 1'b0, rd_val);
        check("mask again", 12'(8'h40), 12'(rd_val));
        reg_read(8'h3C, 1'b0, rd_val);
        check("chan again", 12'(8'h00), 12'(rd_val));
        $display("test mid-run reset done");
        give_verdict();
    end
endmodule
